/* hdl/lspm_regs.vh */
// Constants for the serial port function multiplexer
`ifndef LSPM_REGS_VH
`define LSPM_REGS_VH
`define LSPM_NUM_GROUPS 6
`define LSPM_GROUP_BITS 4
`define LSPM_FUNC_W 3
`define LSPM_FUNC_UART4 3'h0
`define LSPM_FUNC_I2C_GPIO 3'h1
`define LSPM_FUNC_I2C_UART2 3'h2
`define LSPM_FUNC_SPI4 3'h3
`define LSPM_FUNC_GPIO4 3'h4
`define LSPM_FUNC_RESET 3'h4
`define LSPM_UART_GROUPS 2
`define LSPM_XCS_GROUPS 3
`define LSPM_XCS_PER_GROUP 3
`define LSPM_CHAR_MIN 4'h5
`define LSPM_CHAR_MAX 4'h8
`define LSPM_STOP_HALF_MIN 3'h1
`define LSPM_STOP_HALF_MAX 3'h4
`define LSPM_PAR_NONE 2'h0
`define LSPM_PAR_EVEN 2'h1
`define LSPM_PAR_ODD 2'h2
`define LSPM_PAR_SPACE 2'h3
`define LSPM_BAUD_MIN 32'd75
`define LSPM_BAUD_STD_MAX 32'd115200
`define LSPM_BAUD_FAST 32'd4000000
`define LSPM_I2C_MAX_KHZ 32'd3400
`define LSPM_SPI_MAX_KHZ 32'd50000
`define LSPM_SYS_KHZ 32'd100000
`define LSPM_I2C_MIN_DIV (((`LSPM_SYS_KHZ) + (`LSPM_I2C_MAX_KHZ) - 32'd1) / (`LSPM_I2C_MAX_KHZ))
`define LSPM_SPI_MIN_DIV (((`LSPM_SYS_KHZ) + (`LSPM_SPI_MAX_KHZ) - 32'd1) / (`LSPM_SPI_MAX_KHZ))
`endif

/* hdl/lspm_group.v */
// One four-bit serial port group: function decode and pin steering
`timescale 1ns/1ps
`include "lspm_regs.vh"
module lspm_group #(
  parameter UART_OK = 1
) (
  input wire i_clk_sys, // System clock
  input wire i_resetn, // Async reset, active low
  input wire [2:0] i_func, // Requested function
  input wire [3:0] i_pin_in, // Pin levels
  input wire [3:0] i_gpio_out, // GPIO output values
  input wire [3:0] i_gpio_oen, // GPIO output enables, low drives
  input wire i_uart_tx, // UART transmit data
  input wire i_uart_rts_n, // UART ready_for_receive_low
  input wire i_i2c_sda_oen, // I2C data drive, low pulls low
  input wire i_i2c_scl_oen, // I2C clock drive, low pulls low
  input wire i_spi_mosi, // SPI data out
  input wire i_spi_cs_n, // SPI chip select 0
  input wire i_spi_clk, // SPI clock
  output reg [3:0] o_pin_out, // Pin output values
  output reg [3:0] o_pin_oen, // Pin output enables, low drives
  output reg [2:0] o_func, // Accepted function
  output reg o_func_err, // Requested function refused
  output reg o_uart_rx, // UART receive data
  output reg o_uart_cts_n, // UART clear-to-send, active low
  output reg o_i2c_sda, // I2C data in
  output reg o_i2c_scl, // I2C clock in
  output reg o_spi_miso, // SPI data in
  output reg [3:0] o_gpio_in, // GPIO input levels
  output wire o_spi_sel // Group in SPI function
);
  wire uart_req;
  wire valid;
  reg [4:0] st_q;
  reg [4:0] st_d;
  assign uart_req = (i_func == `LSPM_FUNC_UART4) || (i_func == `LSPM_FUNC_I2C_UART2);
  assign valid = (i_func <= `LSPM_FUNC_GPIO4) && ((UART_OK != 0) || !uart_req); // [RQ6]
  // One-hot function state; invalid requests keep the previous function
  localparam [4:0] S_UART4 = 5'h01;
  localparam [4:0] S_I2CG = 5'h02;
  localparam [4:0] S_I2CU = 5'h04;
  localparam [4:0] S_SPI = 5'h08;
  localparam [4:0] S_GPIO = 5'h10;
  always @* begin
    st_d = st_q;
    if (valid) begin
      case (i_func)
        `LSPM_FUNC_UART4: st_d = S_UART4;
        `LSPM_FUNC_I2C_GPIO: st_d = S_I2CG;
        `LSPM_FUNC_I2C_UART2: st_d = S_I2CU;
        `LSPM_FUNC_SPI4: st_d = S_SPI;
        default: st_d = S_GPIO;
      endcase
    end
  end
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= S_GPIO;
      o_func_err <= 1'b0;
    end else begin
      st_q <= st_d; // [RQ1]
      o_func_err <= !valid; // [RQ6]
    end
  end
  assign o_spi_sel = st_q[3];
  // Engine inputs idle when not selected: UART/I2C high, SPI low, GPIO low
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_out <= 4'hf;
      o_pin_oen <= 4'hf;
      o_func <= `LSPM_FUNC_RESET;
      o_uart_rx <= 1'b1;
      o_uart_cts_n <= 1'b1;
      o_i2c_sda <= 1'b1;
      o_i2c_scl <= 1'b1;
      o_spi_miso <= 1'b0;
      o_gpio_in <= 4'h0;
    end else begin
      o_uart_rx <= 1'b1; // [RQ14]
      o_uart_cts_n <= 1'b1;
      o_i2c_sda <= 1'b1;
      o_i2c_scl <= 1'b1;
      o_spi_miso <= 1'b0;
      o_gpio_in <= 4'h0;
      case (st_q)
        S_UART4: begin
          o_func <= `LSPM_FUNC_UART4;
          o_pin_out <= {i_uart_tx, 1'b1, 1'b1, i_uart_rts_n}; // [RQ2]
          o_pin_oen <= 4'b0110;
          o_uart_rx <= i_pin_in[2];
          o_uart_cts_n <= i_pin_in[1];
        end
        S_I2CG: begin
          o_func <= `LSPM_FUNC_I2C_GPIO;
          o_pin_out <= {i_gpio_out[3:2], 2'b00}; // [RQ3]
          o_pin_oen <= {i_gpio_oen[3:2], i_i2c_sda_oen, i_i2c_scl_oen};
          o_gpio_in <= {i_pin_in[3:2], 2'b00};
          o_i2c_sda <= i_pin_in[1];
          o_i2c_scl <= i_pin_in[0];
        end
        S_I2CU: begin
          o_func <= `LSPM_FUNC_I2C_UART2;
          o_pin_out <= {i_uart_tx, 3'b100}; // [RQ4]
          o_pin_oen <= {2'b01, i_i2c_sda_oen, i_i2c_scl_oen};
          o_uart_rx <= i_pin_in[2];
          o_i2c_sda <= i_pin_in[1];
          o_i2c_scl <= i_pin_in[0];
        end
        S_SPI: begin
          o_func <= `LSPM_FUNC_SPI4;
          o_pin_out <= {i_spi_mosi, 1'b1, i_spi_cs_n, i_spi_clk}; // [RQ5]
          o_pin_oen <= 4'b0100;
          o_spi_miso <= i_pin_in[2];
        end
        default: begin
          o_func <= `LSPM_FUNC_GPIO4;
          o_pin_out <= i_gpio_out; // [RQ5]
          o_pin_oen <= i_gpio_oen;
          o_gpio_in <= i_pin_in;
        end
      endcase
    end
  end
endmodule // lspm_group

/* hdl/lspm_mux.v */
// Six-group serial port function multiplexer with engine limit checks
//
// Functional notes
// RQ1 - Six four-bit groups, five selectable functions each
// RQ2 - UART4: tx bit3, rx bit2, cts bit1, rfr bit0
// RQ3 - I2C+GPIO: GPIO bits 3-2, SDA bit1, SCL bit0
// RQ4 - I2C+UART2: tx, rx, SDA, SCL, no flow
// RQ5 - SPI: mosi, miso, cs0, clk; else four GPIOs
// RQ6 - Groups three to six refuse UART functions
// RQ7 - Extra SPI chip selects on groups one-three
// RQ8 - Char 5-8, stop 0.5-2, four parity choices
// RQ9 - Baud 75 to 115200 plus 4 Mbps
// RQ10 - Optional CTS/RFR flow control, hardware or software
// RQ11 - Break, hunt, sticky errors, overflow, FIFO, timeouts; only the four sticky status bits are kept here, no FIFO or timeouts
// RQ12 - I2C clock up to 3.4 MHz
// RQ13 - SPI clock up to 50 MHz, all groups
// RQ14 - Unselected engine inputs held idle
`timescale 1ns/1ps
`include "lspm_regs.vh"
module lspm_mux (
  input wire i_clk_sys, // System clock, 100 MHz
  input wire i_resetn, // Async reset, active low
  input wire [17:0] i_func, // Function per group, 3 bits each
  input wire [23:0] i_pin_in, // Pin levels, 4 per group
  input wire [23:0] i_gpio_out, // GPIO output values
  input wire [23:0] i_gpio_oen, // GPIO output enables, low drives
  input wire [1:0] i_uart_tx, // UART tx, groups 1-2
  input wire [1:0] i_uart_rts_n, // UART ready_for_receive_low from engine
  input wire [1:0] i_uart_flow_en, // Flow control enable
  input wire [1:0] i_uart_flow_hw, // Hardware flow control when high
  input wire [1:0] i_uart_sw_ready_for_receive_low, // Software-driven ready_for_receive_low
  input wire [7:0] i_uart_char_bits, // Character size, 4 bits each
  input wire [5:0] i_uart_stop_half, // Stop length in half bits, 3 bits each
  input wire [3:0] i_uart_parity, // Parity mode, 2 bits each
  input wire [63:0] i_uart_baud, // Baud rate, 32 bits each
  input wire [1:0] i_uart_break_det, // Engine: break seen, pulse
  input wire [1:0] i_uart_hunt_hit, // Engine: hunt character seen, pulse
  input wire [1:0] i_uart_rx_err, // Engine: frame/parity error, pulse
  input wire [1:0] i_uart_overflow, // Engine: overflow, pulse
  input wire [1:0] i_uart_stat_clr, // Clear sticky status, pulse
  input wire [5:0] i_i2c_sda_oen, // I2C data drive, low pulls low
  input wire [5:0] i_i2c_scl_oen, // I2C clock drive, low pulls low
  input wire [47:0] i_i2c_div, // I2C clock divider, 8 bits each
  input wire [5:0] i_spi_mosi, // SPI data out
  input wire [5:0] i_spi_cs_n, // SPI chip select 0
  input wire [5:0] i_spi_clk, // SPI clock
  input wire [47:0] i_spi_div, // SPI clock divider, 8 bits each
  input wire [8:0] i_spi_xcs_n, // Extra chip selects 1-3, groups 1-3
  output wire [23:0] o_pin_out, // Pin output values
  output wire [23:0] o_pin_oen, // Pin output enables, low drives
  output wire [17:0] o_func, // Accepted function per group
  output wire [5:0] o_func_err, // Function request refused
  output wire [1:0] o_uart_rx, // UART rx to engine
  output wire [1:0] o_uart_cts_n, // Clear-to-send to engine
  output reg [1:0] o_uart_tx_hold, // Transmit hold from flow control
  output reg [1:0] o_uart_cfg_err, // UART format or baud unsupported
  output reg [7:0] o_uart_sticky, // Break, hunt, error, overflow per UART
  output wire [5:0] o_i2c_sda, // I2C data in
  output wire [5:0] o_i2c_scl, // I2C clock in
  output reg [5:0] o_i2c_rate_err, // I2C divider gives over 3.4 MHz
  output wire [5:0] o_spi_miso, // SPI data in
  output reg [5:0] o_spi_rate_err, // SPI divider gives over 50 MHz
  output reg [8:0] o_xcs_out, // Extra chip select levels
  output reg [8:0] o_xcs_oen, // Extra chip select enables, low drives
  output wire [23:0] o_gpio_in // GPIO input levels
);
  wire [5:0] spi_sel;
  wire [1:0] cts_n;
  genvar g;
  generate
    for (g = 0; g < `LSPM_NUM_GROUPS; g = g + 1) begin : grp
      wire uart_tx;
      wire rts_n;
      wire rx;
      wire cts;
      if (g < `LSPM_UART_GROUPS) begin : u
        assign uart_tx = i_uart_tx[g];
        // Software flow control replaces the engine level on the pin
        assign rts_n = (i_uart_flow_en[g] && !i_uart_flow_hw[g]) ? i_uart_sw_ready_for_receive_low[g] :
          (i_uart_flow_en[g] ? i_uart_rts_n[g] : 1'b0); // [RQ10]
        assign o_uart_rx[g] = rx;
        assign cts_n[g] = cts;
        assign o_uart_cts_n[g] = cts;
      end else begin : n
        assign uart_tx = 1'b1;
        assign rts_n = 1'b1;
      end
      lspm_group #(
        .UART_OK((g < `LSPM_UART_GROUPS) ? 1 : 0)
      ) u_grp (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_func(i_func[3*g +: 3]),
        .i_pin_in(i_pin_in[4*g +: 4]),
        .i_gpio_out(i_gpio_out[4*g +: 4]),
        .i_gpio_oen(i_gpio_oen[4*g +: 4]),
        .i_uart_tx(uart_tx),
        .i_uart_rts_n(rts_n),
        .i_i2c_sda_oen(i_i2c_sda_oen[g]),
        .i_i2c_scl_oen(i_i2c_scl_oen[g]),
        .i_spi_mosi(i_spi_mosi[g]),
        .i_spi_cs_n(i_spi_cs_n[g]),
        .i_spi_clk(i_spi_clk[g]),
        .o_pin_out(o_pin_out[4*g +: 4]),
        .o_pin_oen(o_pin_oen[4*g +: 4]),
        .o_func(o_func[3*g +: 3]),
        .o_func_err(o_func_err[g]),
        .o_uart_rx(rx),
        .o_uart_cts_n(cts),
        .o_i2c_sda(o_i2c_sda[g]),
        .o_i2c_scl(o_i2c_scl[g]),
        .o_spi_miso(o_spi_miso[g]),
        .o_gpio_in(o_gpio_in[4*g +: 4]),
        .o_spi_sel(spi_sel[g])
      );
      // Divider below the minimum would exceed the engine clock limits
      always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          o_i2c_rate_err[g] <= 1'b0;
          o_spi_rate_err[g] <= 1'b0;
        end else begin
          o_i2c_rate_err[g] <= ({24'h000000, i_i2c_div[8*g +: 8]} < `LSPM_I2C_MIN_DIV); // [RQ12]
          o_spi_rate_err[g] <= spi_sel[g] && ({24'h000000, i_spi_div[8*g +: 8]} < `LSPM_SPI_MIN_DIV); // [RQ13]
        end
      end
    end
    for (g = 0; g < `LSPM_UART_GROUPS; g = g + 1) begin : ucfg
      wire [3:0] cb;
      wire [2:0] sh;
      wire [31:0] bd;
      wire [3:0] ev;
      assign cb = i_uart_char_bits[4*g +: 4];
      assign sh = i_uart_stop_half[3*g +: 3];
      assign bd = i_uart_baud[32*g +: 32];
      assign ev = {i_uart_overflow[g], i_uart_rx_err[g], i_uart_hunt_hit[g], i_uart_break_det[g]};
      always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          o_uart_cfg_err[g] <= 1'b0;
          o_uart_sticky[4*g +: 4] <= 4'h0;
          o_uart_tx_hold[g] <= 1'b0;
        end else begin
          o_uart_cfg_err[g] <= (cb < `LSPM_CHAR_MIN) || (cb > `LSPM_CHAR_MAX) || // [RQ8]
            (sh < `LSPM_STOP_HALF_MIN) || (sh > `LSPM_STOP_HALF_MAX) ||
            !(((bd >= `LSPM_BAUD_MIN) && (bd <= `LSPM_BAUD_STD_MAX)) || (bd == `LSPM_BAUD_FAST)); // [RQ9]
          // Set wins over clear for every sticky bit
          o_uart_sticky[4*g +: 4] <= (i_uart_stat_clr[g] ? 4'h0 : o_uart_sticky[4*g +: 4]) | ev; // [RQ11]
          o_uart_tx_hold[g] <= i_uart_flow_en[g] && i_uart_flow_hw[g] && cts_n[g]; // [RQ10]
        end
      end
    end
    for (g = 0; g < `LSPM_XCS_GROUPS * `LSPM_XCS_PER_GROUP; g = g + 1) begin : xcs
      always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          o_xcs_out[g] <= 1'b1;
          o_xcs_oen[g] <= 1'b1;
        end else begin
          o_xcs_out[g] <= spi_sel[g / `LSPM_XCS_PER_GROUP] ? i_spi_xcs_n[g] : 1'b1; // [RQ7]
          o_xcs_oen[g] <= !spi_sel[g / `LSPM_XCS_PER_GROUP];
        end
      end
    end
  endgenerate
endmodule // lspm_mux

/* sim/lspm_mux_asserts.sv */
// Concurrent checks on the serial port function multiplexer ports
`timescale 1ns/1ps
module lspm_mux_asserts (
  input wire i_clk_sys, // Clock
  input wire i_resetn, // Reset, low
  input wire [17:0] i_func, // Requests
  input wire [5:0] i_spi_mosi, // SPI out
  input wire [1:0] i_uart_tx, // UART tx
  input wire [47:0] i_i2c_div, // I2C div
  input wire [1:0] i_uart_flow_en, // Flow on
  input wire [1:0] i_uart_flow_hw, // HW flow
  input wire [1:0] i_uart_break_det, // Break
  input wire [8:0] i_spi_xcs_n, // Extra CS
  input wire [17:0] o_func, // Accepted
  input wire [5:0] o_func_err, // Refused
  input wire [23:0] o_pin_out, // Pin values
  input wire [23:0] o_pin_oen, // Pin enables
  input wire [1:0] o_uart_cts_n, // CTS
  input wire [1:0] o_uart_tx_hold, // Tx hold
  input wire [7:0] o_uart_sticky, // Sticky
  input wire [5:0] o_i2c_rate_err, // I2C rate
  input wire [8:0] o_xcs_out, // CS levels
  input wire [8:0] o_xcs_oen // CS enables
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_refuse_uart_fn: assert property ((i_func[8:6] == 3'h0 || i_func[8:6] == 3'h2) |=> o_func_err[2])
    else $error("group three took a uart function");
  a_refuse_bad_code: assert property (i_func[2:0] > 3'h4 |=> o_func_err[0])
    else $error("bad function code taken");
  a_uart_tx_pin: assert property (o_func[2:0] == 3'h0 ##1 o_func[2:0] == 3'h0 |->
    o_pin_out[3] == $past(i_uart_tx[0]) && o_pin_oen[3] == 1'b0)
    else $error("uart tx not on bit 3");
  a_spi_pin_map: assert property (o_func[11:9] == 3'h3 ##1 o_func[11:9] == 3'h3 |->
    o_pin_out[15] == $past(i_spi_mosi[3]) && o_pin_oen[15:12] == 4'h4)
    else $error("spi pins wrong on group four");
  a_xcs_route: assert property (o_func[2:0] == 3'h3 ##1 o_func[2:0] == 3'h3 |->
    !o_xcs_oen[0] && o_xcs_out[0] == $past(i_spi_xcs_n[0]))
    else $error("extra chip select not routed");
  a_i2c_rate_chk: assert property (i_i2c_div[7:0] < 8'h1e |=> o_i2c_rate_err[0])
    else $error("i2c rate error missed");
  a_flow_hold: assert property (i_uart_flow_en[0] && i_uart_flow_hw[0] && o_uart_cts_n[0] |=> o_uart_tx_hold[0])
    else $error("tx not held by cts");
  a_sticky_set: assert property (i_uart_break_det[0] |=> o_uart_sticky[0])
    else $error("break not latched");
endmodule // lspm_mux_asserts
bind lspm_mux lspm_mux_asserts i_chk (.*);

/* sim/lspm_far_end.sv */
// Behavioural peripherals on the group pins, with pull-ups
`timescale 1ns/1ps
module lspm_far_end (
  input wire [23:0] i_pin_out, // Device values
  input wire [23:0] i_pin_oen, // Device enables, low drives
  input wire [23:0] i_peer_val, // Peripheral values
  input wire [23:0] i_peer_en, // Peripheral enables
  output wire [23:0] o_pin_in // Resolved levels
);
  // Peripheral raises CTS to throttle the transmitter
  assign o_pin_in = (~i_pin_oen & i_pin_out) | (i_pin_oen & ((i_peer_en & i_peer_val) | ~i_peer_en));
endmodule // lspm_far_end

/* sim/tb.sv */
// Self-checking bench for the serial port function multiplexer
`timescale 1ns/1ps
module tb;
  reg i_clk_sys, i_resetn;
  reg [17:0] i_func;
  reg [23:0] i_gpio_out, i_gpio_oen, peer_val, peer_en;
  reg [1:0] i_uart_tx, i_uart_rts_n, i_uart_flow_en, i_uart_flow_hw, i_uart_sw_ready_for_receive_low, i_uart_stat_clr;
  reg [1:0] i_uart_break_det, i_uart_hunt_hit, i_uart_rx_err, i_uart_overflow;
  reg [7:0] i_uart_char_bits;
  reg [5:0] i_uart_stop_half, i_i2c_sda_oen, i_i2c_scl_oen, i_spi_mosi, i_spi_cs_n, i_spi_clk;
  reg [3:0] i_uart_parity;
  reg [63:0] i_uart_baud;
  reg [47:0] i_i2c_div, i_spi_div;
  reg [8:0] i_spi_xcs_n;
  wire [23:0] i_pin_in, o_pin_out, o_pin_oen, o_gpio_in;
  wire [17:0] o_func;
  wire [5:0] o_func_err, o_i2c_sda, o_i2c_scl, o_i2c_rate_err, o_spi_miso, o_spi_rate_err;
  wire [1:0] o_uart_rx, o_uart_cts_n, o_uart_tx_hold, o_uart_cfg_err;
  wire [7:0] o_uart_sticky;
  wire [8:0] o_xcs_out, o_xcs_oen;
  integer bad_count = 0, samples_checked = 0, cyc = 0, k;
  lspm_mux i_dut (.*);
  lspm_far_end i_peer (.i_pin_out(o_pin_out), .i_pin_oen(o_pin_oen), .i_peer_val(peer_val),
    .i_peer_en(peer_en), .o_pin_in(i_pin_in));
  task step(input integer n);
    begin
      repeat (n) @(posedge i_clk_sys);
      #1;
    end
  endtask
  task chk(input [8*8:1] what, input [23:0] exp, input [23:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      bad_count = bad_count + 1;
      test_done;
    end
  end
  initial begin
    i_resetn = 1'b0;
    i_func = 18'o444444;
    {i_gpio_out, i_gpio_oen, peer_val, peer_en} = {24'h0, 24'hfffff0, 24'h0, 24'h000004};
    {i_uart_tx, i_uart_rts_n, i_uart_flow_en, i_uart_flow_hw, i_uart_sw_ready_for_receive_low, i_uart_stat_clr} = 12'h0;
    {i_uart_break_det, i_uart_hunt_hit, i_uart_rx_err, i_uart_overflow} = 8'h0;
    {i_uart_char_bits, i_uart_stop_half, i_uart_parity} = {8'h88, 6'h12, 4'h0};
    i_uart_baud = {2{32'd115200}};
    {i_i2c_sda_oen, i_i2c_scl_oen, i_spi_mosi, i_spi_cs_n, i_spi_clk} = {12'hfff, 18'h0};
    {i_i2c_div, i_spi_div, i_spi_xcs_n} = {{6{8'h20}}, {6{8'h04}}, 9'h1ff};
    step(6);
    chk("rstfunc", 18'o444444, o_func);
    chk("rstoen", 24'hffffff, o_pin_oen);
    i_resetn = 1'b1;
    for (k = 0; k < 5; k = k + 1) begin
      i_func[2:0] = k;
      step(3);
      chk("func0", k, o_func[2:0]);
      chk("oen0", (20'h04736 >> (4 * k)) & 20'hf, o_pin_oen[3:0]);
      chk("rx0", !(k == 0 || k == 2), o_uart_rx[0]);
    end
    $display("test function table done");
    for (k = 0; k < 3; k = k + 1) begin
      i_func[8:6] = k * 2 + (k == 2);
      step(3);
      chk("err2", 1, o_func_err[2]);
      chk("func2", 4, o_func[8:6]);
    end
    i_func[8:6] = 3'h3;
    i_func[2:0] = 3'h7;
    step(3);
    chk("err2", 0, o_func_err[2]);
    chk("err0", 1, o_func_err[0]);
    chk("func0", 4, o_func[2:0]);
    $display("test refusal done");
    i_func[2:0] = 3'h3;
    i_spi_xcs_n = 9'h1fa;
    peer_val[2] = 1'b1;
    step(3);
    chk("miso0", 1, o_spi_miso[0]);
    chk("xcsoen", 0, o_xcs_oen[2:0]);
    chk("xcsout", 2, o_xcs_out[2:0]);
    $display("test chip selects done");
    for (k = 0; k < 6; k = k + 1) begin
      i_uart_char_bits[3:0] = (k == 0) ? 4'h4 : (k == 5) ? 4'h5 : 4'h8;
      i_uart_stop_half[2:0] = (k == 1) ? 3'h5 : (k == 5) ? 3'h1 : 3'h4;
      i_uart_baud[31:0] = (k == 2) ? 32'd74 : (k == 3) ? 32'd4000000 : (k == 4) ? 32'd115201 : 32'd75;
      i_uart_parity[1:0] = k;
      step(2);
      chk("cfgerr", k < 3 || k == 4, o_uart_cfg_err[0]);
    end
    $display("test uart format done");
    {i_func[2:0], i_uart_flow_en, i_uart_flow_hw, i_uart_rts_n} = {3'h0, 6'h15};
    {peer_en[1], peer_val[1]} = 2'b11;
    step(4);
    chk("hold", 1, o_uart_tx_hold[0]);
    chk("rfrpin", 1, o_pin_out[0]);
    peer_val[1] = 1'b0;
    step(3);
    chk("hold", 0, o_uart_tx_hold[0]);
    $display("test flow control done");
    {i_uart_break_det[0], i_uart_hunt_hit[0], i_uart_rx_err[0], i_uart_overflow[0]} = 4'hf;
    step(1);
    {i_uart_break_det[0], i_uart_hunt_hit[0], i_uart_rx_err[0], i_uart_overflow[0]} = 4'h0;
    step(4);
    chk("sticky", 4'hf, o_uart_sticky[3:0]);
    i_uart_stat_clr[0] = 1'b1;
    step(1);
    i_uart_stat_clr[0] = 1'b0;
    step(2);
    chk("sticky", 0, o_uart_sticky[3:0]);
    $display("test sticky status done");
    for (k = 0; k < 2; k = k + 1) begin
      i_i2c_div[7:0] = 8'h1d + k;
      i_spi_div[23:16] = 8'h01 + k;
      step(2);
      chk("i2crate", 1 - k, o_i2c_rate_err[0]);
      chk("spirate", 1 - k, o_spi_rate_err[2]);
    end
    $display("test clock rates done");
    test_done;
  end
endmodule // tb
